/* File: common/spwm_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the PWM channel
// Assumes: APB with 32-bit data, one word per register
// Notes: Definitions only
`ifndef SPWM_PARAMS_SVH
`define SPWM_PARAMS_SVH

`define SPWM_OFF_MODE_CTRL 12'h000
`define SPWM_OFF_DUTY_UPPER 12'h004
`define SPWM_OFF_PERIOD_LIMIT 12'h008
`define SPWM_OFF_TIMER_CTRL 12'h00C
`define SPWM_OFF_TIMER_COUNT 12'h010
`define SPWM_OFF_DUTY_SHADOW 12'h014
`define SPWM_OFF_STATUS 12'h018

`define SPWM_MODE_LSB 0
`define SPWM_DLOW_LSB 4
`define SPWM_RUN_BIT 2
`define SPWM_PS_LSB 0
`define SPWM_FLAG_BIT 0
`define SPWM_MATCH_BIT 1
`define SPWM_ST_PIN_BIT 2
`define SPWM_ST_DIR_BIT 3

`define SPWM_RST_MODE 8'h00
`define SPWM_RST_DUTY 8'h00
`define SPWM_RST_PERIOD 8'hFF
`define SPWM_RST_TCTRL 8'h00
`define SPWM_RST_COUNT 8'h00

`define SPWM_OSC_PER_TICK 4
`define SPWM_CLK_PERIOD_NS 10

`endif

/* File: common/spwm_pkg.sv */
// Purpose: Types shared by the PWM channel
// Assumes: Constants come from spwm_params.svh
// Notes: No constants here
package spwm_pkg;

   typedef enum logic [1:0] {
      SPWM_OFF,
      SPWM_PWM,
      SPWM_CAPTURE,
      SPWM_COMPARE
   } spwm_kind_t;

   typedef struct packed {
      logic [3:0] mode;
      logic [1:0] duty_low;
   } spwm_ctrl_t;

   typedef struct packed {
      logic run;
      logic [1:0] prescale;
   } spwm_tctrl_t;

endpackage

/* File: logic/spwm_channel.sv */
// Purpose: Standard PWM channel with 8-bit period timer and 10-bit double-buffered duty
// Assumes: APB slave, one clock, sleep freezes state through the clock enable
// Notes: Capture and compare codes are decoded only; their engines live elsewhere
`timescale 1ns/1ps
`include "spwm_params.svh"

module spwm_channel (
   // Clock, reset, sleep gate
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pin
   output logic pwm_output_pin,
   output logic pwm_output_oe,
   // Mode decode
   output logic [1:0] mode_kind
);

   spwm_pkg::spwm_ctrl_t ctrl_q;
   spwm_pkg::spwm_tctrl_t tctrl_q;
   logic [7:0] duty_upper_byte_q;
   logic [7:0] period_limit_q;
   logic [7:0] period_counter_q;
   logic [7:0] duty_shadow_q;
   logic [1:0] duty_latch_q;
   logic [1:0] osc_phase_q;
   logic [3:0] presc_q;
   logic timer_match_flag_q;
   logic match_flag_q;
   logic pin_q;
   logic pin_drive_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [1:0] kind_q;
   logic boundary_q;

   logic pwm_on;
   logic acc;
   logic wr;
   logic tick;
   logic boundary;
   logic [9:0] time_base;
   logic [9:0] duty_buf;
   logic [3:0] presc_max;
   logic [1:0] tb_low;
   logic mapped;
   logic [31:0] rd_word;
   logic wr_mode;
   logic wr_duty_upper;
   logic wr_limit;
   logic wr_tctrl;
   logic wr_count;
   logic wr_shadow;
   logic wr_status;
   logic duty_zero;
   logic [1:0] kind_d;
   logic pin_d;
   logic [7:0] period_counter_d;

   function automatic logic [1:0] decode_kind(input logic [3:0] m);
      logic [1:0] k;
      k = spwm_pkg::SPWM_OFF;
      if (m[3:2] == 2'b11) begin
         k = spwm_pkg::SPWM_PWM;
      end else if (m[3:2] == 2'b01) begin
         k = spwm_pkg::SPWM_CAPTURE;
      end else if (m[3:2] == 2'b10 || m == 4'h2) begin
         k = spwm_pkg::SPWM_COMPARE;
      end
      return k;
   endfunction

   function automatic logic is_addr(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction

   // Prescale codes 1, 4, 16, 16 give terminal counts
   always_comb begin
      unique case (tctrl_q.prescale)
         2'b00: presc_max = 4'h0;
         2'b01: presc_max = 4'h3;
         default: presc_max = 4'hF;
      endcase
   end

   assign pwm_on = decode_kind(ctrl_q.mode) == spwm_pkg::SPWM_PWM;
   assign acc = psel && penable && !pready_q;
   assign wr = acc && pwrite;
   // Counter step: four oscillator phases, then prescaler
   assign tick = tctrl_q.run && (osc_phase_q == 2'(`SPWM_OSC_PER_TICK - 1)) && (presc_q == presc_max);
   assign boundary = tick && (period_counter_q == period_limit_q);
   assign time_base = {period_counter_q, tb_low};
   assign duty_buf = {duty_shadow_q, duty_latch_q};
   assign duty_zero = (duty_buf == 10'h000);

   // One strobe per register keeps the write decode in one place
   assign wr_mode = wr && is_addr(paddr, `SPWM_OFF_MODE_CTRL);
   assign wr_duty_upper = wr && is_addr(paddr, `SPWM_OFF_DUTY_UPPER);
   assign wr_limit = wr && is_addr(paddr, `SPWM_OFF_PERIOD_LIMIT);
   assign wr_tctrl = wr && is_addr(paddr, `SPWM_OFF_TIMER_CTRL);
   assign wr_count = wr && is_addr(paddr, `SPWM_OFF_TIMER_COUNT);
   assign wr_shadow = wr && is_addr(paddr, `SPWM_OFF_DUTY_SHADOW);
   assign wr_status = wr && is_addr(paddr, `SPWM_OFF_STATUS);

   // Low time-base bits step once per clock times prescale ratio
   // At 1:16 the upper prescaler pair, else the pulse would be four times short
   always_comb begin
      unique case (tctrl_q.prescale)
         2'b00: tb_low = osc_phase_q;
         2'b01: tb_low = presc_q[1:0];
         default: tb_low = presc_q[3:2];
      endcase
   end

   // Read word and address check share one decode
   // Unused or unaligned offsets answer with an error and read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         `SPWM_OFF_MODE_CTRL: begin
            rd_word = {26'h000_0000, ctrl_q.duty_low, ctrl_q.mode};
         end
         `SPWM_OFF_DUTY_UPPER: begin
            rd_word = {24'h00_0000, duty_upper_byte_q};
         end
         `SPWM_OFF_PERIOD_LIMIT: begin
            rd_word = {24'h00_0000, period_limit_q};
         end
         `SPWM_OFF_TIMER_CTRL: begin
            rd_word = {29'h0000_0000, tctrl_q.run, tctrl_q.prescale};
         end
         `SPWM_OFF_TIMER_COUNT: begin
            rd_word = {24'h00_0000, period_counter_q};
         end
         `SPWM_OFF_DUTY_SHADOW: begin
            rd_word = {24'h00_0000, duty_shadow_q};
         end
         `SPWM_OFF_STATUS: begin
            rd_word = {28'h000_0000, pin_drive_q, pin_q, match_flag_q, timer_match_flag_q};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Mode control; clock enable low stands for sleep
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= '0;
      end else if (clk_en && wr_mode) begin
         ctrl_q.mode <= pwdata[`SPWM_MODE_LSB +: 4];
         ctrl_q.duty_low <= pwdata[`SPWM_DLOW_LSB +: 2];
      end
   end

   // Duty upper byte
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         duty_upper_byte_q <= `SPWM_RST_DUTY;
      end else if (clk_en && wr_duty_upper) begin
         duty_upper_byte_q <= pwdata[7:0];
      end
   end

   // Period limit
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         period_limit_q <= `SPWM_RST_PERIOD;
      end else if (clk_en && wr_limit) begin
         period_limit_q <= pwdata[7:0];
      end
   end

   // Timer control
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tctrl_q <= '0;
      end else if (clk_en && wr_tctrl) begin
         tctrl_q.run <= pwdata[`SPWM_RUN_BIT];
         tctrl_q.prescale <= pwdata[`SPWM_PS_LSB +: 2];
      end
   end

   // Pin direction bit, software-owned; enable after flag
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_drive_q <= 1'b0;
      end else if (clk_en && wr_status) begin
         pin_drive_q <= pwdata[`SPWM_ST_DIR_BIT];
      end
   end

   // Oscillator phase
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         osc_phase_q <= 2'b00;
      end else if (clk_en && tctrl_q.run) begin
         osc_phase_q <= osc_phase_q + 2'b01;
      end
   end

   // Prescaler, stepped once per four phases
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         presc_q <= 4'h0;
      end else if (clk_en && tctrl_q.run && osc_phase_q == 2'(`SPWM_OSC_PER_TICK - 1)) begin
         presc_q <= (presc_q == presc_max) ? 4'h0 : presc_q + 4'h1;
      end
   end

   // Counter next value; a software load wins over the wrap and the step
   always_comb begin
      period_counter_d = period_counter_q;
      if (wr_count) begin
         period_counter_d = pwdata[7:0];
      end else if (boundary) begin
         period_counter_d = 8'h00;
      end else if (tick) begin
         period_counter_d = period_counter_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         period_counter_q <= `SPWM_RST_COUNT;
      end else if (clk_en) begin
         period_counter_q <= period_counter_d;
      end
   end

   // Duty double buffer; shadow loads at boundary in PWM mode, or from a write outside PWM mode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         duty_shadow_q <= 8'h00;
         duty_latch_q <= 2'b00;
      end else if (clk_en) begin
         if (boundary && pwm_on) begin
            duty_shadow_q <= duty_upper_byte_q;
            duty_latch_q <= ctrl_q.duty_low;
         end else if (!pwm_on && wr_shadow) begin
            duty_shadow_q <= pwdata[7:0];
         end
      end
   end

   // Pin set one clock after the wrap, when the time base reads zero
   // Setting it at the wrap itself would stretch every pulse by one clock
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         boundary_q <= 1'b0;
      end else if (clk_en) begin
         boundary_q <= boundary && pwm_on;
      end
   end

   // Pin next level
   always_comb begin
      pin_d = pin_q;
      if (ctrl_q.mode == 4'h0) begin
         pin_d = 1'b0;
      end else if (pwm_on) begin
         if (boundary_q) begin
            pin_d = !duty_zero;
         end else if (tctrl_q.run && time_base == duty_buf) begin
            pin_d = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_q <= 1'b0;
      end else if (clk_en) begin
         pin_q <= pin_d;
      end
   end

   // Timer flag: hardware set beats software clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timer_match_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (boundary) begin
            timer_match_flag_q <= 1'b1;
         end else if (wr_status && pwdata[`SPWM_FLAG_BIT]) begin
            timer_match_flag_q <= 1'b0;
         end
      end
   end

   // Match flag; the capture and compare engines elsewhere would set it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         match_flag_q <= 1'b0;
      end else if (clk_en && wr_status && pwdata[`SPWM_MATCH_BIT]) begin
         match_flag_q <= 1'b0;
      end
   end

   // APB answer: one wait state, then pready
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped;
      end
   end

   // Read data stands with pready only, zero otherwise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (acc && !pwrite) begin
            prdata_q <= rd_word;
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // Mode kind, registered so the output comes from a flop
   always_comb begin
      kind_d = decode_kind(ctrl_q.mode);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         kind_q <= 2'b00;
      end else if (clk_en) begin
         kind_q <= kind_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pwm_output_pin = pin_q;
   assign pwm_output_oe = pin_drive_q;
   assign mode_kind = kind_q;

endmodule // spwm_channel

/* File: verification/spwm_channel_sva.sv */
// Purpose: Port checker for the PWM channel
// Assumes: Register map of spwm_params.svh
// Notes: Reserved mode codes are left out of the decode check
`timescale 1ns/1ps
module spwm_channel_sva (
   // Clock, reset, sleep gate
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin and decode
   input wire logic pwm_output_pin,
   input wire logic pwm_output_oe,
   input wire logic [1:0] mode_kind
);
   logic [1:0] kind_w;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   assign kind_w = (pwdata[3:2] == 2'h3) ? 2'h1 : (pwdata[3:2] == 2'h1) ? 2'h2 : (pwdata[3:0] == 4'h0) ? 2'h0 : 2'h3;
   chk_ready_answer: assert property (psel && penable && !pready && clk_en |=> pready)
      else $error("no answer after access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_unmapped_err: assert property (pready && !pwrite && paddr >= 12'h01C |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_reset_quiet: assert property ($past(sys_rst) |-> !pwm_output_pin && !pwm_output_oe && mode_kind == 2'h0)
      else $error("outputs not cleared by reset");
   chk_sleep_hold: assert property (!clk_en |=> $stable(pwm_output_pin) && $stable(mode_kind) && $stable(pready))
      else $error("state moved during sleep");
   chk_drive_by_write: assert property ($changed(pwm_output_oe) |-> $past(psel && penable && pwrite && clk_en))
      else $error("driver enable moved without a write");
   chk_pin_in_pwm: assert property ($rose(pwm_output_pin) |-> mode_kind == 2'h1)
      else $error("pin set outside pwm mode");
   chk_mode_decode: assert property (pready && pwrite && clk_en && paddr == 12'h000 && pwdata[3:0] != 4'h1 &&
      pwdata[3:0] != 4'h3 |=> mode_kind == $past(kind_w)) else $error("mode decode wrong");
endmodule // spwm_channel_sva
bind spwm_channel spwm_channel_sva i_sva (.core_clk, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .pwm_output_pin, .pwm_output_oe, .mode_kind);

/* File: verification/spwm_channel_test.sv */
// Purpose: Self-checking bench for the PWM channel
// Assumes: Map and bits of spwm_params.svh
// Notes: Pulse lengths come from the load model
`timescale 1ns/1ps
`include "spwm_params.svh"
module spwm_channel_test;
   logic core_clk = 0, sys_rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdv;
   logic pready, pslverr, pin, oe, erv;
   logic [1:0] mode_kind;
   logic [15:0] hi_len, per_len, rises, r0;
   int mismatches = 0, checks = 0, cyc = 0;
   always #5 core_clk = ~core_clk;
   spwm_channel i_dut (.core_clk, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pwm_output_pin(pin), .pwm_output_oe(oe), .mode_kind);
   spwm_load_model i_load (.core_clk, .sys_rst, .pin, .oe, .hi_len, .per_len, .rises);
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end
   // Edge first, so a release and the next setup never share a time step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset;
      apb(0, `SPWM_OFF_PERIOD_LIMIT, 0);
      chk("limit", rdv, 32'h0000_00FF);
      apb(0, 12'h01C, 0);
      chk("unmapped", {erv, rdv[30:0]}, 32'h8000_0000);
   endtask
   // Limits never shrink between calls, so the counter never runs past them
   task automatic t_pwm(input logic [1:0] ps, input int ratio, input logic [7:0] lim, input logic [9:0] duty);
      apb(1, `SPWM_OFF_PERIOD_LIMIT, lim);
      apb(1, `SPWM_OFF_MODE_CTRL, {2'h0, duty[1:0], 4'hC});
      apb(1, `SPWM_OFF_DUTY_UPPER, duty[9:2]);
      apb(1, `SPWM_OFF_STATUS, 8'h01);
      apb(1, `SPWM_OFF_TIMER_CTRL, {5'h00, 1'b1, ps});
      do apb(0, `SPWM_OFF_STATUS, 0); while (rdv[0] !== 1'b1);
      apb(1, `SPWM_OFF_STATUS, 8'h08);
      repeat (12 * ratio * (lim + 1)) @(posedge core_clk);
      chk("period", per_len, 4 * ratio * (lim + 1));
      chk("high", hi_len, duty * ratio);
      apb(1, `SPWM_OFF_DUTY_SHADOW, 8'h5A);
      apb(0, `SPWM_OFF_DUTY_SHADOW, 0);
      chk("shadow", rdv, duty[9:2]);
   endtask
   task automatic t_sleep;
      clk_en <= 1'b0;
      repeat (2) @(posedge core_clk);
      r0 = rises;
      repeat (1000) @(posedge core_clk);
      chk("sleep", rises, r0);
      clk_en <= 1'b1;
      repeat (600) @(posedge core_clk);
      chk("wake", rises > r0 + 16'h0001, 1);
   endtask
   task automatic t_edge(input logic [7:0] up, input logic lvl);
      apb(1, `SPWM_OFF_MODE_CTRL, 8'h0C);
      apb(1, `SPWM_OFF_DUTY_UPPER, up);
      repeat (600) @(posedge core_clk);
      r0 = rises;
      repeat (600) @(posedge core_clk);
      chk("still pin", {rises, 15'h0000, pin}, {r0, 15'h0000, lvl});
   endtask
   task automatic t_modes;
      logic [1:0] k;
      for (int c = 0; c < 16; c++) begin
         k = (c[3:2] == 2'h3) ? 2'h1 : (c[3:2] == 2'h1) ? 2'h2 : (c == 0) ? 2'h0 : 2'h3;
         if (c != 1 && c != 3) begin
            apb(1, `SPWM_OFF_MODE_CTRL, c[7:0]);
            @(posedge core_clk);
            chk("mode kind", mode_kind, k);
         end
      end
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_pwm(2'h0, 1, 8'h01, 10'h005);
      t_pwm(2'h1, 4, 8'h03, 10'h009);
      t_pwm(2'h2, 16, 8'h03, 10'h00B);
      t_sleep();
      t_edge(8'h00, 1'b0);
      t_edge(8'hFF, 1'b1);
      t_modes();
      final_report();
   end
endmodule // spwm_channel_test

/* File: verification/spwm_load_model.sv */
// Purpose: Load on the PWM pin, measures pulses in clock cycles
// Assumes: Pull-down holds the line low while the driver is off
// Notes: Lengths are those of the last complete pulse
`timescale 1ns/1ps
module spwm_load_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Pin
   input wire logic pin,
   input wire logic oe,
   // Measurements
   output logic [15:0] hi_len,
   output logic [15:0] per_len,
   output logic [15:0] rises
);
   logic lvl_q;
   logic [15:0] cnt_q;
   always_ff @(posedge core_clk) begin
      lvl_q <= oe & pin;
      cnt_q <= (oe & pin & !lvl_q) ? 16'h0001 : cnt_q + 16'h0001;
      if (oe & pin & !lvl_q) begin
         per_len <= cnt_q;
      end
      if (!(oe & pin) & lvl_q) begin
         hi_len <= cnt_q;
      end
      rises <= sys_rst ? 16'h0000 : rises + {15'h0000, oe & pin & !lvl_q};
   end
endmodule // spwm_load_model
